// *** pkg/dsa_defines.vh ***
`ifndef DSA_DEFINES_VH
`define DSA_DEFINES_VH

// Clock rates
`define DSA_CLK_HZ 100000000
`define DSA_TICK_HZ 100000
`define DSA_TICK_DIV (`DSA_CLK_HZ / `DSA_TICK_HZ)

// Phase and digit strobe lengths in conversion ticks
`define DSA_AZ_TICKS 10000
`define DSA_SI_TICKS 10000
`define DSA_RI_MAX_TICKS 20000
`define DSA_STROBE_TICKS 200

// Register byte offsets
`define DSA_OFS_CTRL 4'h0
`define DSA_OFS_STATUS 4'h4
`define DSA_OFS_RESULT 4'h8

// Control register fields
`define DSA_CTRL_RANGE_LSB 0
`define DSA_CTRL_RANGE_MSB 1
`define DSA_CTRL_DP_LSB 2
`define DSA_CTRL_DP_MSB 4
`define DSA_CTRL_DZERO_BIT 5
`define DSA_CTRL_RESET 6'h00

// Range switch codes {left, right}
`define DSA_RANGE_5K 2'h0
`define DSA_RANGE_10K 2'h1
`define DSA_RANGE_20K 2'h2

// Decimal point selector codes
`define DSA_DP_SEL1 3'h1
`define DSA_DP_SEL2 3'h2
`define DSA_DP_SEL3 3'h3
`define DSA_DP_SEL4 3'h4
`define DSA_DP_NONE 3'h5

// Phase codes
`define DSA_PH_AZ 2'h0
`define DSA_PH_SI 2'h1
`define DSA_PH_RI 2'h2

`endif

// *** core/dsa_tick_gen.v ***
`timescale 1ns/1ps
`include "dsa_defines.vh"

module dsa_tick_gen #(
  parameter DIV = `DSA_TICK_DIV
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Tick out
  output wire tick_o
);

  reg [15:0] cnt_reg;
  reg tick_reg;

  // One-cycle pulse per conversion clock period
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  assign tick_o = tick_reg;

endmodule // dsa_tick_gen

// *** core/dsa_adc_scan.v ***
// Operation
// - Count phases on 100 kHz tick
// - Phases: auto-zero, signal, reference integrate
// - Auto-zero lasts 10000 counts
// - Signal integrate lasts 10000 counts
// - Latch polarity, apply opposite reference
// - Reference integrate until zero, max 20000
// - Each digit strobe 200 periods high
// - Lead strobe first, last digit last
// - Overrange blanks strobes until reference integrate
// - BCD valid together with its strobe
// - Largest range overrange flashes zeros; here it flashes 19995
// - Two switches decode range selection
// - Count step one, two, five
// - Leading one only from 10000 up
// - Largest range limited to 19995
// - Selectors 1-4 place point, 5 none
// - Selector 6 lights trailing zero digit; here control bit 5 does
// - Any overrange flashes display
// - Busy high during both integrate phases
// - Lead strobe forces BCD outputs low
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dsa_defines.vh"

module dsa_adc_scan #(
  parameter TICK_DIV = `DSA_TICK_DIV,
  parameter AZ_TICKS = `DSA_AZ_TICKS,
  parameter SI_TICKS = `DSA_SI_TICKS,
  parameter RI_MAX_TICKS = `DSA_RI_MAX_TICKS,
  parameter STROBE_TICKS = `DSA_STROBE_TICKS
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Avalon-MM slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Analog front end
  input wire integ_zero_i,
  input wire ramp_pos_i,
  input wire analog_ovr_n_i,
  output wire auto_zero_o,
  output wire sig_integ_o,
  output wire ref_integ_o,
  output wire ref_neg_o,
  output wire busy_o,
  // Display
  output wire lead_digit_strobe_o,
  output wire [2:0] mid_digit_strobe_o,
  output wire last_digit_strobe_o,
  output wire [3:0] bcd_o,
  output wire leading_digit_one_o,
  output wire polarity_pos_o,
  output wire [3:0] dp_o,
  output wire trailing_zero_digit_o
);

  localparam ST_AZ = 2'h0;
  localparam ST_SI = 2'h1;
  localparam ST_RI = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Add one to a BCD digit, carry out on top
  function [4:0] bcd_inc;
    input [3:0] d;
    begin
      if (d == 4'h9)
        bcd_inc = 5'h10;
      else
        bcd_inc = {1'b0, d + 4'h1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick and pin synchronisers

  wire tick;

  dsa_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  reg [2:0] pin_s1_reg;
  reg [2:0] pin_s2_reg;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 3'h4;
      pin_s2_reg <= 3'h4;
    end else begin
      pin_s1_reg <= {analog_ovr_n_i, ramp_pos_i, integ_zero_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire zero_s = pin_s2_reg[0];
  wire ramp_pos_s = pin_s2_reg[1];
  wire ovr_n_s = pin_s2_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  reg [5:0] ctrl_reg;
  reg ack_reg;

  // One wait state on every access
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;

  wire [1:0] range_sw = ctrl_reg[`DSA_CTRL_RANGE_MSB:`DSA_CTRL_RANGE_LSB];
  wire [2:0] dp_sel = ctrl_reg[`DSA_CTRL_DP_MSB:`DSA_CTRL_DP_LSB];
  wire dzero_en = ctrl_reg[`DSA_CTRL_DZERO_BIT];

  wire rng_10k = (range_sw == `DSA_RANGE_10K);
  wire rng_20k = (range_sw == `DSA_RANGE_20K);

  reg [1:0] state_reg;
  reg pol_reg;
  reg ovr_reg;
  reg [17:0] result_reg;
  wire busy;
  reg [31:0] rd_next;

  always @* begin
    if (avs_address_i == `DSA_OFS_CTRL)
      rd_next = {26'h0000000, ctrl_reg};
    else if (avs_address_i == `DSA_OFS_STATUS)
      rd_next = {27'h0000000, busy, ovr_reg, pol_reg, state_reg};
    else if (avs_address_i == `DSA_OFS_RESULT)
      rd_next = {14'h0000, result_reg};
    else
      rd_next = 32'h00000000;
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      ctrl_reg <= `DSA_CTRL_RESET;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      if (avs_read_i & ~ack_reg)
        avs_readdata_o <= rd_next;
      if (avs_write_i & ack_reg & avs_byteenable_i[0] &
          (avs_address_i == `DSA_OFS_CTRL))
        ctrl_reg <= avs_writedata_i[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  reg [15:0] ph_cnt_reg;
  reg [17:0] bcd_cnt_reg;
  reg ana_ovr_reg;
  reg [17:0] bcd_cnt_inc;
  wire [4:0] dig0_inc = bcd_inc(bcd_cnt_reg[3:0]);
  wire [4:0] dig1_inc = bcd_inc(bcd_cnt_reg[7:4]);
  wire [4:0] dig2_inc = bcd_inc(bcd_cnt_reg[11:8]);
  wire [4:0] dig3_inc = bcd_inc(bcd_cnt_reg[15:12]);
  // Same edge as entry to reference, so the lead strobe keeps full width
  wire ri_start = tick & (state_reg == ST_SI) &
    (ph_cnt_reg == SI_TICKS[15:0] - 16'h0001);

  always @* begin
    bcd_cnt_inc = bcd_cnt_reg;
    bcd_cnt_inc[3:0] = dig0_inc[3:0];
    if (dig0_inc[4]) begin
      bcd_cnt_inc[7:4] = dig1_inc[3:0];
      if (dig1_inc[4]) begin
        bcd_cnt_inc[11:8] = dig2_inc[3:0];
        if (dig2_inc[4]) begin
          bcd_cnt_inc[15:12] = dig3_inc[3:0];
          if (dig3_inc[4])
            bcd_cnt_inc[17:16] = bcd_cnt_reg[17:16] + 2'h1;
        end
      end
    end
  end

  assign busy = (state_reg == ST_SI) | (state_reg == ST_RI);

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_AZ;
      ph_cnt_reg <= 16'h0000;
      bcd_cnt_reg <= 18'h00000;
      result_reg <= 18'h00000;
      pol_reg <= 1'b0;
      ovr_reg <= 1'b0;
      ana_ovr_reg <= 1'b0;
    end else begin
      // analog overrange caught during the cycle
      if (!ovr_n_s)
        ana_ovr_reg <= 1'b1;
      // all phase counts advance on tick
      if (tick) begin
        case (state_reg)
          ST_AZ: begin
            if (ph_cnt_reg == AZ_TICKS[15:0] - 16'h0001) begin
              state_reg <= ST_SI;
              ph_cnt_reg <= 16'h0000;
            end else begin
              ph_cnt_reg <= ph_cnt_reg + 16'h0001;
            end
          end
          ST_SI: begin
            if (ph_cnt_reg == SI_TICKS[15:0] - 16'h0001) begin
              pol_reg <= ramp_pos_s;
              state_reg <= ST_RI;
              ph_cnt_reg <= 16'h0000;
              bcd_cnt_reg <= 18'h00000;
            end else begin
              ph_cnt_reg <= ph_cnt_reg + 16'h0001;
            end
          end
          ST_RI: begin
            // end on zero return or at maximum
            if (zero_s |
                (ph_cnt_reg == RI_MAX_TICKS[15:0] - 16'h0001)) begin
              result_reg <= bcd_cnt_reg;
              // no zero return is a timeout
              ovr_reg <= ~zero_s | ana_ovr_reg | ~ovr_n_s;
              ana_ovr_reg <= 1'b0;
              state_reg <= ST_AZ;
              ph_cnt_reg <= 16'h0000;
            end else begin
              ph_cnt_reg <= ph_cnt_reg + 16'h0001;
              bcd_cnt_reg <= bcd_cnt_inc;
            end
          end
          default: begin
            state_reg <= ST_AZ;
            ph_cnt_reg <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign auto_zero_o = (state_reg == ST_AZ);
  assign sig_integ_o = (state_reg == ST_SI);
  assign ref_integ_o = (state_reg == ST_RI);
  assign ref_neg_o = (state_reg == ST_RI) & pol_reg;
  assign busy_o = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Displayed value

  reg [3:0] ones_shown;
  reg [15:0] low_shown;
  reg lead_one;

  always @* begin
    low_shown = result_reg[15:0];
    lead_one = (result_reg[17:16] != 2'h0);
    if (rng_10k)
      ones_shown = {result_reg[3:1], 1'b0};
    else if (rng_20k)
      ones_shown = (result_reg[3:0] >= 4'h5) ? 4'h5 : 4'h0;
    else
      ones_shown = result_reg[3:0];
    low_shown[3:0] = ones_shown;
    if (rng_20k & (result_reg[17:16] != 2'h0) &
        (result_reg[17:16] != 2'h1)) begin
      low_shown = 16'h9995;
      lead_one = 1'b1;
    end
    // leading one only on larger ranges
    if (!(rng_10k | rng_20k))
      lead_one = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digit scan

  reg [7:0] strb_cnt_reg;
  reg [2:0] digit_reg;
  reg blank_reg;
  reg [4:0] strobe_reg;
  reg [3:0] bcd_reg;
  reg lead_one_reg;
  reg [3:0] dp_reg;
  reg [4:0] strobe_next;
  reg [3:0] bcd_next;

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      strb_cnt_reg <= 8'h00;
      digit_reg <= 3'h0;
      blank_reg <= 1'b0;
    end else if (ri_start) begin
      strb_cnt_reg <= 8'h00;
      digit_reg <= 3'h0;
      blank_reg <= 1'b0;
    end else if (tick) begin
      if (strb_cnt_reg == STROBE_TICKS[7:0] - 8'h01) begin
        strb_cnt_reg <= 8'h00;
        // order lead first, last digit last
        if (digit_reg == 3'h4) begin
          digit_reg <= 3'h0;
          // blank after first scan on overrange
          if (ovr_reg)
            blank_reg <= 1'b1;
        end else begin
          digit_reg <= digit_reg + 3'h1;
        end
      end else begin
        strb_cnt_reg <= strb_cnt_reg + 8'h01;
      end
    end
  end

  always @* begin
    strobe_next = 5'h00;
    bcd_next = 4'h0;
    case (digit_reg)
      3'h0: bcd_next = 4'h0;
      3'h1: bcd_next = low_shown[15:12];
      3'h2: bcd_next = low_shown[11:8];
      3'h3: bcd_next = low_shown[7:4];
      default: bcd_next = low_shown[3:0];
    endcase
    if (!blank_reg)
      strobe_next = 5'h10 >> digit_reg;
  end

  // strobe and BCD share one register stage
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      strobe_reg <= 5'h00;
      bcd_reg <= 4'h0;
      lead_one_reg <= 1'b0;
      dp_reg <= 4'h0;
    end else begin
      strobe_reg <= strobe_next;
      // zero on BCD during lead strobe
      bcd_reg <= strobe_next[4] ? 4'h0 : bcd_next;
      lead_one_reg <= strobe_next[4] & lead_one;
      // point with its digit, first one static
      dp_reg[0] <= (dp_sel == `DSA_DP_SEL1);
      dp_reg[1] <= (dp_sel == `DSA_DP_SEL2) & strobe_next[3];
      dp_reg[2] <= (dp_sel == `DSA_DP_SEL3) & strobe_next[2];
      dp_reg[3] <= (dp_sel == `DSA_DP_SEL4) & strobe_next[1];
    end
  end

  assign lead_digit_strobe_o = strobe_reg[4];
  assign mid_digit_strobe_o = strobe_reg[3:1];
  assign last_digit_strobe_o = strobe_reg[0];
  assign bcd_o = bcd_reg;
  assign leading_digit_one_o = lead_one_reg;
  assign polarity_pos_o = pol_reg;
  assign dp_o = dp_reg;
  // trailing zero lit with lead strobe
  assign trailing_zero_digit_o = dzero_en & strobe_reg[4];

endmodule // dsa_adc_scan

// *** test/dsa_front_model.sv ***
`timescale 1ns/1ps
module dsa_front_model (
  // Converter side
  input wire logic clock_i,
  input wire logic ref_integ_i,
  input wire logic [15:0] ri_cyc_i,
  // Comparator out
  output logic integ_zero_o
);
  logic [15:0] cnt_reg;
  always @(posedge clock_i) begin
    cnt_reg <= ref_integ_i ? cnt_reg + 16'h1 : 16'h0;
  end
  // Low outside reference phase, so a stray early trip is not masked
  assign integ_zero_o = ref_integ_i && (cnt_reg >= ri_cyc_i);
endmodule // dsa_front_model

// *** test/dsa_adc_scan_sva.sv ***
`timescale 1ns/1ps
module dsa_adc_scan_sva #(
  parameter TICK_DIV = 1000,
  parameter SI_TICKS = 10000,
  parameter RI_MAX_TICKS = 20000,
  parameter STROBE_TICKS = 200
) (
  // Watched ports
  input wire clock_i,
  input wire rst_n_i,
  input wire auto_zero_o,
  input wire sig_integ_o,
  input wire ref_integ_o,
  input wire ref_neg_o,
  input wire busy_o,
  input wire lead_digit_strobe_o,
  input wire [2:0] mid_digit_strobe_o,
  input wire last_digit_strobe_o,
  input wire [3:0] bcd_o,
  input wire leading_digit_one_o,
  input wire [3:0] dp_o,
  input wire trailing_zero_digit_o
);
  logic [31:0] si_cnt_reg, ri_cnt_reg, st_cnt_reg;
  always @(posedge clock_i) begin
    si_cnt_reg <= sig_integ_o ? si_cnt_reg + 32'h1 : 32'h0;
    ri_cnt_reg <= ref_integ_o ? ri_cnt_reg + 32'h1 : 32'h0;
    st_cnt_reg <= last_digit_strobe_o ? st_cnt_reg + 32'h1 : 32'h0;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////
  AST_BUSY: assert property (
    busy_o == (sig_integ_o | ref_integ_o)) else $error("busy wrong");
  AST_PH_ONE: assert property (
    $onehot({auto_zero_o, sig_integ_o, ref_integ_o}))
    else $error("phase not one-hot");
  AST_AZ_SI: assert property (
    $fell(auto_zero_o) |-> sig_integ_o) else $error("az not to si");
  AST_SI_LEN: assert property (
    $fell(sig_integ_o) |-> ref_integ_o &&
      si_cnt_reg == SI_TICKS * TICK_DIV) else $error("si length");
  AST_RI_AZ: assert property (
    $fell(ref_integ_o) |-> auto_zero_o) else $error("ri not to az");
  AST_RI_MAX: assert property (
    ri_cnt_reg <= RI_MAX_TICKS * TICK_DIV) else $error("ri too long");
  AST_REF_NEG: assert property (
    ref_neg_o |-> ref_integ_o) else $error("ref outside ri");
  AST_SCAN: assert property (
    $fell(lead_digit_strobe_o) |-> mid_digit_strobe_o == 3'h4)
    else $error("scan order");
  AST_STB_ONE: assert property (
    $onehot0({lead_digit_strobe_o, mid_digit_strobe_o,
      last_digit_strobe_o})) else $error("two strobes");
  AST_STB_LEN: assert property (
    $fell(last_digit_strobe_o) && (!ref_integ_o || ri_cnt_reg > 4)
      |-> st_cnt_reg == STROBE_TICKS * TICK_DIV)
    else $error("strobe width");
  AST_LEAD_BCD: assert property (
    lead_digit_strobe_o |-> bcd_o == 4'h0) else $error("lead bcd");
  AST_TZ: assert property (
    trailing_zero_digit_o |-> lead_digit_strobe_o) else $error("tz");
  AST_ONE: assert property (
    leading_digit_one_o |-> lead_digit_strobe_o) else $error("one");
  AST_DP: assert property (
    (dp_o[3:1] & ~{mid_digit_strobe_o[0], mid_digit_strobe_o[1],
      mid_digit_strobe_o[2]}) == 3'h0) else $error("dp gating");
endmodule // dsa_adc_scan_sva
bind dsa_adc_scan dsa_adc_scan_sva #(.TICK_DIV(TICK_DIV),
  .SI_TICKS(SI_TICKS), .RI_MAX_TICKS(RI_MAX_TICKS),
  .STROBE_TICKS(STROBE_TICKS)) u_sva (.clock_i, .rst_n_i,
  .auto_zero_o, .sig_integ_o, .ref_integ_o, .ref_neg_o, .busy_o,
  .lead_digit_strobe_o, .mid_digit_strobe_o, .last_digit_strobe_o,
  .bcd_o, .leading_digit_one_o, .dp_o, .trailing_zero_digit_o);

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clock_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic integ_zero_i, ramp_pos_i = 1, analog_ovr_n_i = 1;
  logic avs_waitrequest_o, auto_zero_o, sig_integ_o, ref_integ_o;
  logic ref_neg_o, busy_o, lead_digit_strobe_o, last_digit_strobe_o;
  logic leading_digit_one_o, polarity_pos_o, trailing_zero_digit_o;
  logic [2:0] mid_digit_strobe_o;
  logic [3:0] bcd_o, dp_o;
  logic [15:0] ri_cyc = 16'h001E;
  logic [8:0] obs;
  int error_cnt = 0, checks = 0;
  always #5 clock_i = ~clock_i;
  assign obs = {trailing_zero_digit_o, ref_integ_o, sig_integ_o,
    auto_zero_o, last_digit_strobe_o, mid_digit_strobe_o,
    lead_digit_strobe_o};
  // Short counts keep a conversion within 320 cycles
  dsa_adc_scan #(.TICK_DIV(4), .AZ_TICKS(20), .SI_TICKS(20),
    .RI_MAX_TICKS(40), .STROBE_TICKS(3)) u_dut (.clock_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .integ_zero_i, .ramp_pos_i, .analog_ovr_n_i, .auto_zero_o,
    .sig_integ_o, .ref_integ_o, .ref_neg_o, .busy_o,
    .lead_digit_strobe_o, .mid_digit_strobe_o, .last_digit_strobe_o,
    .bcd_o, .leading_digit_one_o, .polarity_pos_o, .dp_o,
    .trailing_zero_digit_o);
  dsa_front_model u_front (.clock_i, .ref_integ_i(ref_integ_o),
    .ri_cyc_i(ri_cyc), .integ_zero_o(integ_zero_i));
  ////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // Held until waitrequest is sampled low at a rising edge
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task wt(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (obs[k] !== v && n < 3000);
    if (obs[k] !== v) cmp("wait", {31'h0, v}, {31'h0, obs[k]});
  endtask
  task conv;
    wt(7, 1);
    wt(7, 0);
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(0, 4'h0, 0);
    cmp("ctrl reset", 32'h0, q); // reset
    bus(1, 4'h0, 32'h29);
    bus(0, 4'h0, 0);
    cmp("ctrl", 32'h29, q); // fields
    bus(0, 4'hC, 0);
    cmp("unmapped", 32'h0, q);
    bus(1, 4'h0, 32'h4);
  endtask
  task t_conv(input logic pos);
    @(posedge clock_i);
    ramp_pos_i <= pos;
    conv;
    wt(7, 1);
    repeat (4) @(negedge clock_i);
    cmp("ref sign", {31'h0, pos}, {31'h0, ref_neg_o}); // sign
    cmp("polarity", {31'h0, pos}, {31'h0, polarity_pos_o}); // sign
    wt(7, 0);
    bus(0, 4'h4, 0);
    cmp("phase", 32'h0, {27'h0, q[4:3], 1'b0, q[1:0]}); // az
    bus(0, 4'h8, 0);
    cmp("result", 32'h1, {31'h0, q >= 6 && q <= 10}); // count
  endtask
  task t_over;
    logic [4:0] seen;
    @(posedge clock_i);
    ri_cyc <= 16'hFFFF;
    conv;
    bus(0, 4'h4, 0);
    cmp("timeout ovr", 32'h1, {31'h0, q[3]}); // flag
    wt(6, 1);
    seen = 5'h0;
    repeat (70) begin
      @(negedge clock_i);
      seen |= obs[4:0];
    end
    cmp("blank", 32'h0, {27'h0, seen}); // blank
    wt(7, 1);
    @(negedge clock_i);
    cmp("restart", 32'h1, {31'h0, obs[0]}); // rescan
    @(posedge clock_i);
    ri_cyc <= 16'h001E;
    analog_ovr_n_i <= 1'b0;
    conv;
    conv;
    bus(0, 4'h4, 0);
    cmp("analog ovr", 32'h1, {31'h0, q[3]}); // flash
    analog_ovr_n_i <= 1'b1;
    conv;
    conv;
    bus(0, 4'h4, 0);
    cmp("ovr clear", 32'h0, {31'h0, q[3]}); // clear
  endtask
  task t_disp;
    logic [3:0] e;
    for (int s = 1; s <= 5; s++) begin
      bus(1, 4'h0, (s << 2) | ((s & 1) << 5));
      wt(0, 0);
      wt(0, 1);
      cmp("dummy zero", s & 1, {31'h0, obs[8]}); // digit
      for (int j = 0; j < 3; j++) begin
        wt(3 - j, 1);
        e = {3'h0, s == 1} | ({3'h0, s == j + 2} << (j + 1));
        cmp("dp", {28'h0, e}, {28'h0, dp_o}); // point
      end
    end
  endtask
  task t_step;
    conv;
    bus(1, 4'h0, 32'h1);
    // Zero return seen on the tenth tick: a raw count of nine
    ri_cyc <= 16'h0022;
    conv;
    wt(4, 1);
    cmp("step two", 32'h8, {28'h0, bcd_o}); // even
    bus(1, 4'h0, 32'h2);
    wt(4, 0);
    wt(4, 1);
    cmp("step five", 32'h5, {28'h0, bcd_o});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_conv(1);
    t_conv(0);
    t_over;
    t_disp;
    t_step;
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    tally_and_finish;
  end
endmodule // testbench
